// file: shsr_defines.vh
// Constants for the standby controller: widths, stabilization codes, counts.
// Assumes inclusion by bare name from the standby controller files.
`ifndef SHSR_DEFINES_VH
`define SHSR_DEFINES_VH

`define SHSR_STABILIZATION_TIME_SELECT_W 3
`define SHSR_STABILIZATION_TIME_SELECT_RESET 3'h4
`define SHSR_STABILIZATION_TIME_SELECT_2E12 3'h0
`define SHSR_STABILIZATION_TIME_SELECT_2E15 3'h2
`define SHSR_STABILIZATION_TIME_SELECT_2E17 3'h4
`define SHSR_CNT_W 18
`define SHSR_WAIT_2E12 18'h01000
`define SHSR_WAIT_2E15 18'h08000
`define SHSR_WAIT_2E17 18'h20000

`endif

// file: shsr_stab_counter.v
// Oscillation stabilization counter of main clock cycles.
// Assumes i_start pulses when the oscillator restarts.
`timescale 1ns/1ps
`include "shsr_defines.vh"

module shsr_stab_counter #(
    parameter CNT_W = `SHSR_CNT_W
) (
    input wire i_mclk,
    input wire i_reset,
    input wire i_start,
    input wire [CNT_W-1:0] i_target,
    output reg o_busy,
    output reg o_done
);
    reg [CNT_W-1:0] count;
    reg [CNT_W-1:0] target;

    // ==========================================
    // Counter
    always @(posedge i_mclk) begin
        if (i_reset) begin
            count <= {CNT_W{1'b0}};
            target <= {CNT_W{1'b0}};
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                count <= {{(CNT_W-1){1'b0}}, 1'b1};
                target <= i_target;
                o_busy <= 1'b1;
            end else if (o_busy) begin
                if (count >= target) begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                end else begin
                    count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// file: shsr_standby_ctrl.v
// Standby controller: HALT and STOP entry, wake-up and peripheral gating.
// Assumes CPU instruction strobes, interrupt flags and reset are synchronous
// to i_mclk, and that i_reset_pin is the device reset input seen by this block.
`timescale 1ns/1ps
`include "shsr_defines.vh"

module shsr_standby_ctrl #(
    parameter CNT_W = `SHSR_CNT_W,
    parameter PORT_W = 8
) (
    input wire i_mclk,
    input wire i_reset,
    input wire i_reset_pin,
    input wire i_halt_instr,
    input wire i_stop_instr,
    input wire i_irq_pending,
    input wire i_nmi_req,
    input wire i_global_interrupt_enable,
    input wire i_stabilization_time_select_we,
    input wire [2:0] i_stabilization_time_select,
    input wire i_subclk_running,
    input wire i_wide_timer_subclk_sel,
    input wire i_wide_timer_buzzer_en,
    input wire i_event_counter_a_ext_sel,
    input wire i_event_counter_b_ext_sel,
    input wire i_narrow_timer_c_subclk_sel,
    input wire i_watch_timer_subclk_sel,
    input wire i_serial_ext_clk_sel,
    input wire i_two_wire_bus_port_addr_match,
    input wire [PORT_W-1:0] i_port_latch,
    output reg [2:0] o_stabilization_time_select,
    output wire o_halt_mode,
    output wire o_stop_mode,
    output wire o_main_osc_en,
    output wire o_cpu_run,
    output reg o_cpu_reset,
    output reg o_vector_irq,
    output reg o_vector_nmi,
    output reg o_resume_next,
    output reg [PORT_W-1:0] o_port_latch,
    output wire o_wide_timer_en,
    output wire o_event_counter_a_en,
    output wire o_event_counter_b_en,
    output wire o_narrow_timer_c_en,
    output wire o_watch_timer_en,
    output wire o_serial_en,
    output wire o_two_wire_bus_port_wake,
    output wire o_watchdog_en,
    output wire o_adc_en,
    output wire o_mult_en
);
    localparam [5:0] ST_RUN = 6'h01;
    localparam [5:0] ST_HALT = 6'h02;
    localparam [5:0] ST_STOP = 6'h04;
    localparam [5:0] ST_WAIT = 6'h08;
    localparam [5:0] ST_RSTWAIT = 6'h10;
    localparam [5:0] ST_PEND = 6'h20;

    reg [5:0] state;
    reg [5:0] next_state;
    reg stab_start;
    reg [CNT_W-1:0] stab_target;
    wire stab_busy;
    wire stab_done;
    wire stopped;

    // ==========================================
    // Stabilization code decode
    function [CNT_W-1:0] shsr_wait_count;
        input [2:0] code;
        begin
            case (code)
                `SHSR_STABILIZATION_TIME_SELECT_2E12: shsr_wait_count = `SHSR_WAIT_2E12;
                `SHSR_STABILIZATION_TIME_SELECT_2E15: shsr_wait_count = `SHSR_WAIT_2E15;
                `SHSR_STABILIZATION_TIME_SELECT_2E17: shsr_wait_count = `SHSR_WAIT_2E17;
                default: shsr_wait_count = `SHSR_WAIT_2E17;
            endcase
        end
    endfunction

    // Unit runs outside STOP, or in STOP while its condition holds
    function shsr_stop_gate;
        input in_stop_mode;
        input keep_running;
        begin
            shsr_stop_gate = !in_stop_mode || keep_running;
        end
    endfunction

    shsr_stab_counter #(
        .CNT_W(CNT_W)
    ) u_stab (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_start(stab_start),
        .i_target(stab_target),
        .o_busy(stab_busy),
        .o_done(stab_done)
    );

    // ==========================================
    // State decode and wake conditions
    wire in_run;
    wire in_halt;
    wire in_stop;
    wire in_wait;
    wire in_rstwait;
    wire in_pend;
    wire stop_entry;
    wire halt_entry;
    wire pin_quiet;
    wire halt_nmi_wake;
    wire halt_irq_wake;
    wire entry_nmi_wake;
    wire entry_irq_wake;
    wire stop_irq_done;
    wire maskable_wake;
    wire reset_hold;
    wire reset_release;
    wire units_off;

    assign in_run = (state == ST_RUN);
    assign in_halt = (state == ST_HALT);
    assign in_stop = (state == ST_STOP);
    assign in_wait = (state == ST_WAIT);
    assign in_rstwait = (state == ST_RSTWAIT);
    assign in_pend = (state == ST_PEND);

    // Stop wins when both instructions arrive together
    assign stop_entry = in_run && i_stop_instr;
    assign halt_entry = in_run && i_halt_instr && !i_stop_instr;
    // Reset pin overrides every wake action
    assign pin_quiet = !i_reset_pin;
    assign halt_nmi_wake = in_halt && i_nmi_req && pin_quiet;
    assign halt_irq_wake = in_halt && i_irq_pending && pin_quiet;
    assign entry_nmi_wake = halt_entry && i_nmi_req &&
        pin_quiet;
    assign entry_irq_wake = halt_entry && i_irq_pending &&
        pin_quiet;
    assign stop_irq_done = in_wait && stab_done && pin_quiet;
    assign maskable_wake = halt_irq_wake || stop_irq_done || entry_irq_wake;
    assign reset_hold = i_reset_pin || in_pend || in_rstwait;
    assign reset_release = in_rstwait && stab_done && pin_quiet;
    assign units_off = in_stop || in_halt || in_wait;

    // ==========================================
    // Stabilization target: reset wait ignores the select code
    always @* begin
        if (in_pend) begin
            stab_target = `SHSR_WAIT_2E15;
        end else begin
            stab_target = shsr_wait_count(o_stabilization_time_select);
        end
    end

    // ==========================================
    // Stabilization counter start
    always @* begin
        stab_start = 1'b0;
        case (state)
            ST_RUN: begin
                stab_start = stop_entry && i_irq_pending;
            end
            ST_STOP: begin
                stab_start = i_irq_pending;
            end
            ST_PEND: begin
                stab_start = 1'b1;
            end
            default: begin
                stab_start = 1'b0;
            end
        endcase
        // Counting waits until the reset pin is released
        if (i_reset_pin) begin
            stab_start = 1'b0;
        end
    end

    // ==========================================
    // Stabilization select register
    always @(posedge i_mclk) begin
        if (i_reset) begin
            o_stabilization_time_select <= `SHSR_STABILIZATION_TIME_SELECT_RESET;
        end else if (i_stabilization_time_select_we) begin
            o_stabilization_time_select <= i_stabilization_time_select;
        end
    end

    // ==========================================
    // Mode sequencer
    always @* begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (stop_entry) begin
                    next_state = ST_STOP;
                    if (i_irq_pending) begin
                        next_state = ST_WAIT;
                    end
                end else if (halt_entry) begin
                    next_state = ST_HALT;
                    if (i_irq_pending || i_nmi_req) begin
                        next_state = ST_RUN;
                    end
                end
            end
            ST_HALT: begin
                if (i_nmi_req || i_irq_pending) begin
                    next_state = ST_RUN;
                end
            end
            ST_STOP: begin
                if (i_irq_pending) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (stab_done) begin
                    next_state = ST_RUN;
                end
            end
            ST_RSTWAIT: begin
                if (stab_done) begin
                    next_state = ST_RUN;
                end
            end
            ST_PEND: begin
                next_state = ST_RSTWAIT;
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
        if (i_reset_pin) begin
            next_state = ST_PEND;
        end
    end

    always @(posedge i_mclk) begin
        if (i_reset) begin
            state <= ST_PEND;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================
    // CPU wake actions
    always @(posedge i_mclk) begin
        if (i_reset) begin
            o_cpu_reset <= 1'b1;
            o_vector_irq <= 1'b0;
            o_vector_nmi <= 1'b0;
            o_resume_next <= 1'b0;
        end else begin
            o_vector_irq <= 1'b0;
            o_vector_nmi <= 1'b0;
            o_resume_next <= 1'b0;
            if (reset_hold) begin
                o_cpu_reset <= !reset_release;
            end else begin
                o_cpu_reset <= 1'b0;
            end
            // NMI in HALT takes precedence over a maskable wake
            if (halt_nmi_wake) begin
                o_vector_nmi <= 1'b1;
            end else if (maskable_wake) begin
                o_vector_irq <= i_global_interrupt_enable;
                o_resume_next <= !i_global_interrupt_enable;
            end else if (entry_nmi_wake) begin
                o_vector_nmi <= 1'b1;
            end
        end
    end

    // ==========================================
    // Port latch hold
    always @(posedge i_mclk) begin
        if (i_reset) begin
            o_port_latch <= {PORT_W{1'b0}};
        end else if (!stopped) begin
            o_port_latch <= i_port_latch;
        end
    end

    // ==========================================
    // Clock, CPU and peripheral gating
    wire wide_keep;
    wire event_a_keep;
    wire event_b_keep;
    wire narrow_keep;
    wire watch_keep;
    wire serial_keep;

    assign stopped = in_stop;
    assign o_stop_mode = stopped;
    assign o_halt_mode = in_halt || in_wait;
    assign o_main_osc_en = !stopped;
    assign o_cpu_run = in_run;

    assign wide_keep = i_wide_timer_subclk_sel &&
        i_wide_timer_buzzer_en &&
        i_subclk_running;
    assign event_a_keep = i_event_counter_a_ext_sel;
    assign event_b_keep = i_event_counter_b_ext_sel;
    assign narrow_keep = i_narrow_timer_c_subclk_sel && i_subclk_running;
    assign watch_keep = i_watch_timer_subclk_sel && i_subclk_running;
    assign serial_keep = i_serial_ext_clk_sel;

    assign o_wide_timer_en = shsr_stop_gate(stopped, wide_keep);
    assign o_event_counter_a_en = shsr_stop_gate(stopped, event_a_keep);
    assign o_event_counter_b_en = shsr_stop_gate(stopped, event_b_keep);
    assign o_narrow_timer_c_en = shsr_stop_gate(stopped, narrow_keep);
    assign o_watch_timer_en = shsr_stop_gate(stopped, watch_keep);
    assign o_serial_en = shsr_stop_gate(stopped, serial_keep);
    assign o_two_wire_bus_port_wake = i_two_wire_bus_port_addr_match;
    assign o_watchdog_en = !units_off;
    assign o_adc_en = in_run;
    assign o_mult_en = in_run;
endmodule

// file: shsr_cpu_model.sv
// CPU stand-in: turns HALT/STOP requests into strobes, logs wake answers.
// Assumes the controller clock; strobes leave only while the CPU runs.
`timescale 1ns/1ps
module shsr_cpu_model (
    input wire i_mclk,
    input wire i_cpu_run,
    input wire i_halt_req,
    input wire i_stop_req,
    input wire i_vector_irq,
    input wire i_vector_nmi,
    input wire i_resume_next,
    output logic o_halt_instr = 1'b0,
    output logic o_stop_instr = 1'b0,
    output logic [1:0] o_wake = 2'h0
);
    // ==========
    // Strobes and wake log
    always @(posedge i_mclk) begin
        o_halt_instr <= i_halt_req && i_cpu_run;
        o_stop_instr <= i_stop_req && i_cpu_run;
        if (i_halt_req || i_stop_req) o_wake <= 2'h0;
        else if (i_resume_next) o_wake <= 2'h1;
        else if (i_vector_irq) o_wake <= 2'h2;
        else if (i_vector_nmi) o_wake <= 2'h3;
    end
endmodule

// file: shsr_standby_ctrl_checker.sv
// Port assertions for the standby controller.
// Assumes a bind into shsr_standby_ctrl; one clock, sync reset.
`timescale 1ns/1ps
module shsr_standby_ctrl_checker #(
    parameter PORT_W = 8
) (
    input wire i_mclk, i_reset, i_reset_pin, i_stop_instr, i_irq_pending,
    input wire i_subclk_running, i_wide_timer_subclk_sel, i_wide_timer_buzzer_en,
    input wire i_event_counter_a_ext_sel, i_event_counter_b_ext_sel,
    input wire i_narrow_timer_c_subclk_sel, i_watch_timer_subclk_sel,
    input wire i_serial_ext_clk_sel, i_two_wire_bus_port_addr_match,
    input wire o_stop_mode, o_main_osc_en, o_cpu_run, o_cpu_reset,
    input wire o_vector_irq, o_vector_nmi, o_resume_next,
    input wire [PORT_W-1:0] o_port_latch,
    input wire o_wide_timer_en, o_event_counter_a_en, o_event_counter_b_en,
    input wire o_narrow_timer_c_en, o_watch_timer_en, o_serial_en,
    input wire o_two_wire_bus_port_wake, o_watchdog_en, o_adc_en, o_mult_en
);
    // ==========
    // Properties
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    wire calm = !i_reset_pin && !i_irq_pending;
    property p_stop_clk; o_stop_mode |-> !o_main_osc_en && !o_cpu_run; endproperty
    a_stop_clk: assert property (p_stop_clk) else $error("osc or cpu on");
    property p_hold; o_stop_mode && $past(o_stop_mode) |-> $stable(o_port_latch); endproperty
    a_hold: assert property (p_hold) else $error("port latch moved");
    property p_gate_a; o_stop_mode |-> o_wide_timer_en == (i_subclk_running &&
        i_wide_timer_subclk_sel && i_wide_timer_buzzer_en) && o_narrow_timer_c_en ==
        (i_subclk_running && i_narrow_timer_c_subclk_sel) && o_watch_timer_en ==
        (i_subclk_running && i_watch_timer_subclk_sel); endproperty
    a_gate_a: assert property (p_gate_a) else $error("subclock gating");
    property p_gate_b; o_stop_mode |-> {o_event_counter_a_en, o_event_counter_b_en,
        o_serial_en, o_two_wire_bus_port_wake} == {i_event_counter_a_ext_sel,
        i_event_counter_b_ext_sel, i_serial_ext_clk_sel, i_two_wire_bus_port_addr_match};
    endproperty
    a_gate_b: assert property (p_gate_b) else $error("ext gating");
    property p_stop_in; o_cpu_run && i_stop_instr && calm |=> o_stop_mode; endproperty
    a_stop_in: assert property (p_stop_in) else $error("no stop");
    property p_keep; o_stop_mode && calm |=> o_stop_mode; endproperty
    a_keep: assert property (p_keep) else $error("stop left");
    property p_idle; o_stop_mode |-> !(o_watchdog_en || o_adc_en || o_mult_en); endproperty
    a_idle: assert property (p_idle) else $error("unit on in stop");
    property p_pin; i_reset_pin |=> o_cpu_reset && !o_cpu_run && !o_vector_irq; endproperty
    a_pin: assert property (p_pin) else $error("reset pin");
    c_irq: cover property (o_vector_irq);
    c_resume: cover property (o_resume_next);
    c_nmi: cover property (o_vector_nmi);
endmodule
bind shsr_standby_ctrl shsr_standby_ctrl_checker #(.PORT_W(PORT_W)) u_chk (.*);

// file: tb_top.sv
// Self-checking bench for the standby controller.
// Assumes the CPU stand-in and the bound checker are compiled first.
`timescale 1ns/1ps
module tb_top;
    logic i_mclk = 1'b0, i_reset = 1'b1, i_reset_pin = 1'b0, i_irq_pending = 1'b0;
    logic i_nmi_req = 1'b0, i_global_interrupt_enable = 1'b0, i_stabilization_time_select_we = 1'b0;
    logic halt_req = 1'b0, stop_req = 1'b0;
    logic [2:0] i_stabilization_time_select = 3'h0;
    logic [7:0] i_port_latch = 8'h5A;
    logic [8:0] gate = 9'h000;
    wire i_halt_instr, i_stop_instr, i_subclk_running, i_wide_timer_subclk_sel;
    wire i_wide_timer_buzzer_en, i_event_counter_a_ext_sel, i_event_counter_b_ext_sel;
    wire i_narrow_timer_c_subclk_sel, i_watch_timer_subclk_sel, i_serial_ext_clk_sel;
    wire i_two_wire_bus_port_addr_match, o_halt_mode, o_stop_mode, o_main_osc_en;
    wire o_cpu_run, o_cpu_reset, o_vector_irq, o_vector_nmi, o_resume_next, o_serial_en;
    wire o_wide_timer_en, o_event_counter_a_en, o_event_counter_b_en, o_narrow_timer_c_en;
    wire o_watch_timer_en, o_two_wire_bus_port_wake, o_watchdog_en, o_adc_en, o_mult_en;
    wire [2:0] o_stabilization_time_select;
    wire [7:0] o_port_latch;
    wire [1:0] wake;
    int fail_count = 0, checks = 0, cycles = 0, n, k;
    assign {i_subclk_running, i_wide_timer_subclk_sel, i_wide_timer_buzzer_en,
        i_event_counter_a_ext_sel, i_event_counter_b_ext_sel, i_narrow_timer_c_subclk_sel,
        i_watch_timer_subclk_sel, i_serial_ext_clk_sel, i_two_wire_bus_port_addr_match} = gate;
    shsr_standby_ctrl dut (.*);
    shsr_cpu_model cpu (.i_mclk, .i_cpu_run(o_cpu_run), .i_halt_req(halt_req),
        .i_stop_req(stop_req), .i_vector_irq(o_vector_irq), .i_vector_nmi(o_vector_nmi),
        .i_resume_next(o_resume_next), .o_halt_instr(i_halt_instr),
        .o_stop_instr(i_stop_instr), .o_wake(wake));
    always #2.5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 90000) begin
            fail_count++;
            test_done();
        end
    end
    // ==========
    // Tasks
    task automatic test_done;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [31:0] got, lo, hi);
        checks++;
        if ($isunknown(got) || got < lo || got > hi) begin
            fail_count++;
            $display("unexpected at %0t got %0h lo %0h hi %0h", $time, got, lo, hi);
        end
    endtask
    task automatic wait_run(output int c);
        c = 0;
        while (o_cpu_run !== 1'b1 && c < 40000) begin
            @(posedge i_mclk);
            #1;
            c++;
        end
    endtask
    task automatic instr(input logic stop);
        @(posedge i_mclk);
        halt_req <= !stop;
        stop_req <= stop;
        @(posedge i_mclk);
        halt_req <= 1'b0;
        stop_req <= 1'b0;
        @(posedge i_mclk);
        #1;
    endtask
    // ==========
    // Tests
    initial begin
        repeat (4) @(posedge i_mclk);
        i_reset <= 1'b0;
        #1;
        chk(o_stabilization_time_select, 3'h4);
        wait_run(n);
        chk_rng(n, 32768, 32780);
        @(posedge i_mclk);
        i_stabilization_time_select_we <= 1'b1;
        @(posedge i_mclk);
        i_stabilization_time_select_we <= 1'b0;
        #1;
        chk(o_stabilization_time_select, 3'h0);
        $display("test reset done");
        for (k = 0; k < 3; k++) begin
            instr(1'b0);
            repeat (8) @(posedge i_mclk);
            #1;
            chk(o_halt_mode, 1'b1);
            @(posedge i_mclk);
            i_global_interrupt_enable <= k[0];
            i_irq_pending <= (k != 2);
            i_nmi_req <= (k == 2);
            @(posedge i_mclk);
            i_irq_pending <= 1'b0;
            i_nmi_req <= 1'b0;
            repeat (3) @(posedge i_mclk);
            #1;
            chk(wake, k + 1);
            $display("test halt %0d done", k);
        end
        @(posedge i_mclk);
        i_nmi_req <= 1'b1;
        instr(1'b0);
        @(posedge i_mclk);
        i_nmi_req <= 1'b0;
        #1;
        chk(wake, 3);
        chk(o_cpu_run, 1'b1);
        $display("test halt pending done");
        for (k = 0; k < 3; k++) begin
            @(posedge i_mclk);
            i_global_interrupt_enable <= (k != 1);
            i_irq_pending <= (k == 2);
            gate <= k ? 9'h09C : 9'h1EB;
            instr(1'b1);
            chk(o_stop_mode, k != 2);
            chk(o_halt_mode, k == 2);
            if (k < 2) begin
                @(posedge i_mclk);
                i_port_latch <= 8'hA5;
                repeat (4) @(posedge i_mclk);
                #1;
                chk(o_port_latch, 8'h5A);
                chk({o_wide_timer_en, o_event_counter_a_en, o_event_counter_b_en,
                    o_narrow_timer_c_en, o_watch_timer_en, o_serial_en, o_two_wire_bus_port_wake},
                    {gate[8] & gate[7] & gate[6], gate[5:4], gate[8] & gate[3],
                    gate[8] & gate[2], gate[1:0]});
                chk({o_main_osc_en, o_watchdog_en, o_adc_en, o_mult_en}, 4'h0);
                @(posedge i_mclk);
                i_irq_pending <= 1'b1;
                i_port_latch <= 8'h5A;
            end
            wait_run(n);
            chk_rng(n, 4094, 4104);
            @(posedge i_mclk);
            i_irq_pending <= 1'b0;
            repeat (2) @(posedge i_mclk);
            #1;
            chk(wake, k == 1 ? 1 : 2);
            $display("test stop %0d done", k);
        end
        instr(1'b1);
        @(posedge i_mclk);
        i_reset_pin <= 1'b1;
        repeat (3) @(posedge i_mclk);
        i_reset_pin <= 1'b0;
        #1;
        chk(o_cpu_reset, 1'b1);
        wait_run(n);
        chk_rng(n, 32768, 32780);
        chk(o_cpu_reset, 1'b0);
        $display("test stop reset done");
        test_done();
    end
endmodule
